// [hw/vectored_irq_command_regs.sv]
// Command, status and vector register set of a 32-source vectored irq block
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps

module vectored_irq_command_regs (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] address,
   input wire logic [31:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [31:0] readData,
   // Interrupt source levels, active high
   input wire logic [31:0] sourceLevel,
   // Processor request lines, active low
   output logic fast_request_out_n,
   output logic normal_request_out_n,
   // Status to the rest of the system
   output logic protection_enable,
   output logic serviceBusy,
   output logic eventIrq
);

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [31:0] enabled;
      logic [31:0] pending;
      logic [31:0] fastForce;
      logic [31:0] spuriousVector;
      logic [31:0] sourceVector0;
      logic [31:0] normalVector;
      logic [1:0] debugCtrl;
      logic [4:0] currentSource;
      vectored_irq_pkg::service_type service;
      logic [1:0] eventStatus;
      logic [1:0] eventMask;
      logic [31:0] readData;
      logic fastN;
      logic normalN;
      logic protection;
      logic busy;
      logic irq;
   } state_type;

   state_type r;
   state_type next_r;

   // Lowest numbered set bit picks the source to serve
   function automatic logic [4:0] lowestSet(input logic [31:0] v);
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            idx = i[4:0];
         end
      end
      return idx;
   endfunction

   function automatic logic isWrite(input logic [7:0] ofs,
                                    input logic [7:0] adr,
                                    input logic we);
      return we && (adr == ofs);
   endfunction

   // One-hot word with a single source bit set
   function automatic logic [31:0] oneHot(input int pos);
      logic [31:0] w;
      w = vectored_irq_pkg::ZERO_WORD;
      w[pos] = 1'b1;
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] fastCand;
   logic [31:0] normalCand;
   logic fastActive;
   logic normalActive;
   logic [1:0] events;
   logic lineHold;
   logic fastLevel;
   logic normalLevel;

   ////////////////////////////////////////////////////////////////////////
   // Register map, byte offsets (names in the package)
   //   0x00 source vector 0, read/write
   //   0x04 normal vector, read-only; a hit enters service
   //   0x08 fast vector, read-only
   //   0x0c pending, read-only
   //   0x10 enable mask, read-only
   //   0x14 core line status, read-only
   //   0x20 enable command, write-only
   //   0x24 disable command, write-only
   //   0x28 pending clear command, write-only
   //   0x2c pending set command, write-only
   //   0x30 end of service command, write-only, data ignored
   //   0x34 spurious vector, read/write
   //   0x38 debug control, read/write, two bits
   //   0x40 fast force enable command, write-only
   //   0x44 fast force disable command, write-only
   //   0x48 fast force state, read-only
   //   0x50 event status, cleared by its read
   //   0x54 event mask, read/write
   // Any other offset reads zero and swallows writes.

   ////////////////////////////////////////////////////////////////////////
   // Write decode, one strobe per writable location; read-only offsets
   // have no strobe at all, so writes to them cannot touch state
   logic wrEnable;
   logic wrDisable;
   logic wrClear;
   logic wrSet;
   logic wrFastOn;
   logic wrFastOff;
   logic wrSpurious;
   logic wrVector0;
   logic wrDebug;
   logic wrEventMask;
   logic wrEndService;

   always_comb begin
      wrEnable = isWrite(vectored_irq_pkg::SOURCE_ENABLE_CMD_OFS,
                         address, writeStrobe);
      wrDisable = isWrite(vectored_irq_pkg::SOURCE_DISABLE_CMD_OFS,
                          address, writeStrobe);
      wrClear = isWrite(vectored_irq_pkg::PENDING_CLEAR_CMD_OFS,
                        address, writeStrobe);
      wrSet = isWrite(vectored_irq_pkg::PENDING_SET_CMD_OFS,
                      address, writeStrobe);
      wrFastOn = isWrite(vectored_irq_pkg::FAST_FORCE_ENABLE_CMD_OFS,
                         address, writeStrobe);
      wrFastOff = isWrite(vectored_irq_pkg::FAST_FORCE_DISABLE_CMD_OFS,
                          address, writeStrobe);
      wrSpurious = isWrite(vectored_irq_pkg::SPURIOUS_VECTOR_OFS,
                           address, writeStrobe);
      wrVector0 = isWrite(vectored_irq_pkg::SOURCE_VECTOR0_OFS,
                          address, writeStrobe);
      wrDebug = isWrite(vectored_irq_pkg::DEBUG_CONTROL_OFS,
                        address, writeStrobe);
      wrEventMask = isWrite(vectored_irq_pkg::EVENT_MASK_OFS,
                            address, writeStrobe);
      wrEndService = isWrite(vectored_irq_pkg::END_OF_SERVICE_CMD_OFS,
                             address, writeStrobe);
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r = r;

      // Pending latches high source levels until cleared; software set wins over clear
      next_r.pending = r.pending | sourceLevel;
      if (wrClear) begin
         next_r.pending = next_r.pending & ~writeData;
      end
      if (wrSet) begin
         next_r.pending = next_r.pending | writeData;
      end

      // Enable and disable never meet: one address per cycle
      if (wrEnable) begin
         next_r.enabled = r.enabled | writeData;
      end
      if (wrDisable) begin
         next_r.enabled = r.enabled & ~writeData;
      end
      if (wrFastOn) begin
         next_r.fastForce = r.fastForce
            | (writeData & vectored_irq_pkg::FAST_FORCE_IMPL_MASK);
      end
      if (wrFastOff) begin
         next_r.fastForce = r.fastForce & ~writeData;
      end
      if (wrSpurious) begin
         next_r.spuriousVector = writeData;
      end
      if (wrVector0) begin
         next_r.sourceVector0 = writeData;
      end
      if (wrDebug) begin
         next_r.debugCtrl = writeData[1:0]
            & vectored_irq_pkg::DEBUG_IMPL_MASK;
      end
      if (wrEventMask) begin
         next_r.eventMask = writeData[1:0];
      end

      // Any data value completes the service in progress
      if (wrEndService) begin
         next_r.service = vectored_irq_pkg::SERVICE_IDLE;
         next_r.currentSource = '0;
      end

      // Normal vector read acknowledges the source being served
      // The handler reads the vector before it writes end of service; a
      // second read while busy is refused by the idle-service check and gets the spurious one
      next_r.readData = vectored_irq_pkg::ZERO_WORD;
      if (readStrobe) begin
         case (address)
            vectored_irq_pkg::SOURCE_VECTOR0_OFS:
               next_r.readData = r.sourceVector0;
            vectored_irq_pkg::NORMAL_VECTOR_OFS: begin
               if (normalActive) begin
                  next_r.readData = r.normalVector;
                  next_r.currentSource = lowestSet(normalCand);
                  next_r.service = vectored_irq_pkg::SERVICE_NORMAL;
               end else begin
                  next_r.readData = r.spuriousVector;
               end
            end
            vectored_irq_pkg::FAST_VECTOR_OFS: begin
               if (fastActive) begin
                  next_r.readData = r.sourceVector0;
               end else begin
                  next_r.readData = r.spuriousVector;
               end
            end
            vectored_irq_pkg::PENDING_OFS:
               next_r.readData = r.pending;
            vectored_irq_pkg::MASK_OFS:
               next_r.readData = r.enabled;
            vectored_irq_pkg::CORE_LINE_STATUS_OFS: begin
               next_r.readData[vectored_irq_pkg::FAST_LINE_STATE_BIT] =
                  ~r.fastN;
               next_r.readData[vectored_irq_pkg::NORMAL_LINE_STATE_BIT] =
                  ~r.normalN;
            end
            vectored_irq_pkg::SPURIOUS_VECTOR_OFS:
               next_r.readData = r.spuriousVector;
            vectored_irq_pkg::DEBUG_CONTROL_OFS:
               next_r.readData[1:0] = r.debugCtrl;
            vectored_irq_pkg::FAST_FORCE_STATE_OFS:
               next_r.readData = r.fastForce;
            vectored_irq_pkg::EVENT_STATUS_OFS: begin
               next_r.readData[1:0] = r.eventStatus;
               next_r.eventStatus = 2'h0;
            end
            vectored_irq_pkg::EVENT_MASK_OFS:
               next_r.readData[1:0] = r.eventMask;
            default:
               next_r.readData = vectored_irq_pkg::ZERO_WORD;
         endcase
      end

      // Set wins over the clear-on-read
      next_r.eventStatus = next_r.eventStatus | events;

      // Vector of the candidate; only source 0 has a stored vector here
      next_r.normalVector = (lowestSet(normalCand) == 5'h00)
         ? r.sourceVector0 : r.spuriousVector;

      // Lines are active low; the levels come from the block below
      next_r.fastN = ~fastLevel;
      next_r.normalN = ~normalLevel;
      next_r.protection =
         next_r.debugCtrl[vectored_irq_pkg::PROTECTION_ENABLE_BIT];
      next_r.busy = (next_r.service != vectored_irq_pkg::SERVICE_IDLE);
      next_r.irq = |(next_r.eventStatus & next_r.eventMask);
   end

   // Forced sources leave the normal path entirely
   always_comb begin
      fastCand = r.pending & r.enabled
         & (r.fastForce
            | oneHot(vectored_irq_pkg::FAST_SOURCE_BIT));
      normalCand = r.pending & r.enabled & ~fastCand;
      fastActive = |fastCand;
      // A normal request waits until the current service completes
      normalActive = (|normalCand)
         && (r.service == vectored_irq_pkg::SERVICE_IDLE);
   end

   // Events seen this cycle; the status word holds them until read
   always_comb begin
      events = '0;
      events[vectored_irq_pkg::EVT_END_OF_SERVICE_BIT] =
         wrEndService;
      if (readStrobe && (address == vectored_irq_pkg::NORMAL_VECTOR_OFS)
          && !normalActive) begin
         events[vectored_irq_pkg::EVT_SPURIOUS_READ_BIT] = 1'b1;
      end
      if (readStrobe && (address == vectored_irq_pkg::FAST_VECTOR_OFS)
          && !fastActive) begin
         events[vectored_irq_pkg::EVT_SPURIOUS_READ_BIT] = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request line levels; the global mask beats every source, so software
   // can silence the core without touching enables or pending bits
   always_comb begin
      lineHold = r.debugCtrl[vectored_irq_pkg::GLOBAL_LINE_MASK_BIT];
      fastLevel = fastActive && !lineHold;
      normalLevel = normalActive && !lineHold;
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         // Lines reset high so the core sees no request while reset holds
         r <= '0;
         r.fastN <= 1'b1;
         r.normalN <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // Every output is a flip-flop of the state word, no logic after it
   assign readData = r.readData;
   assign fast_request_out_n = r.fastN;
   assign normal_request_out_n = r.normalN;
   assign protection_enable = r.protection;
   assign serviceBusy = r.busy;
   assign eventIrq = r.irq;

endmodule

// [hw/vectored_irq_pkg.sv]
// Package: register map, field positions and reset values of the irq block
package vectored_irq_pkg;
   localparam int NUM_SOURCES = 32;
   localparam int ADDR_WIDTH = 8;
   localparam int DATA_WIDTH = 32;

   // Register byte offsets
   localparam logic [7:0] SOURCE_VECTOR0_OFS = 8'h00;
   localparam logic [7:0] NORMAL_VECTOR_OFS = 8'h04;
   localparam logic [7:0] FAST_VECTOR_OFS = 8'h08;
   localparam logic [7:0] PENDING_OFS = 8'h0c;
   localparam logic [7:0] MASK_OFS = 8'h10;
   localparam logic [7:0] CORE_LINE_STATUS_OFS = 8'h14;
   localparam logic [7:0] SOURCE_ENABLE_CMD_OFS = 8'h20;
   localparam logic [7:0] SOURCE_DISABLE_CMD_OFS = 8'h24;
   localparam logic [7:0] PENDING_CLEAR_CMD_OFS = 8'h28;
   localparam logic [7:0] PENDING_SET_CMD_OFS = 8'h2c;
   localparam logic [7:0] END_OF_SERVICE_CMD_OFS = 8'h30;
   localparam logic [7:0] SPURIOUS_VECTOR_OFS = 8'h34;
   localparam logic [7:0] DEBUG_CONTROL_OFS = 8'h38;
   localparam logic [7:0] FAST_FORCE_ENABLE_CMD_OFS = 8'h40;
   localparam logic [7:0] FAST_FORCE_DISABLE_CMD_OFS = 8'h44;
   localparam logic [7:0] FAST_FORCE_STATE_OFS = 8'h48;
   localparam logic [7:0] EVENT_STATUS_OFS = 8'h50;
   localparam logic [7:0] EVENT_MASK_OFS = 8'h54;

   // Field positions
   localparam int FAST_LINE_STATE_BIT = 0;
   localparam int NORMAL_LINE_STATE_BIT = 1;
   localparam int PROTECTION_ENABLE_BIT = 0;
   localparam int GLOBAL_LINE_MASK_BIT = 1;
   localparam int FAST_SOURCE_BIT = 0;
   localparam int SYSTEM_SOURCE_BIT = 1;

   // Event status bits
   localparam int EVT_END_OF_SERVICE_BIT = 0;
   localparam int EVT_SPURIOUS_READ_BIT = 1;
   localparam int EVENT_WIDTH = 2;

   // Reset values and masks
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   localparam logic [31:0] FAST_FORCE_IMPL_MASK = 32'hffff_fffe;
   localparam logic [1:0] DEBUG_IMPL_MASK = 2'h3;

   typedef enum logic [1:0] {
      SERVICE_IDLE = 2'b00,
      SERVICE_NORMAL = 2'b01,
      SERVICE_FAST = 2'b10
   } service_type;
endpackage

// [bench/vectored_irq_assertions.sv]
// Checker: port-level properties of the irq command register block
`timescale 1ns/10ps
module vectored_irq_assertions (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Register port
   input wire logic [7:0] address,
   input wire logic [31:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   input wire logic [31:0] readData,
   // Request lines and service state
   input wire logic fast_request_out_n,
   input wire logic normal_request_out_n,
   input wire logic serviceBusy
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////
   sequence wr(logic [7:0] a);
      writeStrobe && address == a;
   endsequence
   sequence rd(logic [7:0] a);
      readStrobe && address == a;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   // Status shows the line as it stood when the read was taken
   fast_state_a: assert property (
      rd(8'h14) |=> readData[0] == !$past(fast_request_out_n))
      else $error("fast line status mismatch");
   normal_state_a: assert property (
      rd(8'h14) |=> readData[1] == !$past(normal_request_out_n))
      else $error("normal line status mismatch");
   enable_mask_a: assert property (
      wr(8'h20) ##1 rd(8'h10) |=>
         (readData & $past(writeData, 2)) == $past(writeData, 2))
      else $error("enabled source missing from mask");
   disable_mask_a: assert property (
      wr(8'h24) ##1 rd(8'h10) |=>
         (readData & $past(writeData, 2)) == 32'h0000_0000)
      else $error("disabled source still in mask");
   spurious_back_a: assert property (
      wr(8'h34) ##1 rd(8'h34) |=> readData == $past(writeData, 2))
      else $error("spurious vector not read back");
   line_mask_a: assert property (
      wr(8'h38) && writeData[1] |-> ##2
         fast_request_out_n && normal_request_out_n)
      else $error("request line active under global mask");
   force_bit0_a: assert property (
      rd(8'h48) |=> !readData[0])
      else $error("fast force bit 0 reads set");
   service_end_a: assert property (
      wr(8'h30) |=> !serviceBusy)
      else $error("service still busy after end write");
   command_zero_a: assert property (
      readStrobe && address inside {8'h20, 8'h24, 8'h2c, 8'h30} |=>
         readData == 32'h0000_0000)
      else $error("command register read not zero");
endmodule

// [bench/core_request_model.sv]
// Processor core model: latches fast and normal requests it has seen
`timescale 1ns/10ps
module core_request_model (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Request lines, active low
   input wire logic fast_request_out_n,
   input wire logic normal_request_out_n,
   // Seen flags
   output logic fastTaken,
   output logic normalTaken
);
   // Sticky, so a short request is still visible to the bench later
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fastTaken <= 1'b0;
         normalTaken <= 1'b0;
      end else begin
         fastTaken <= fastTaken || !fast_request_out_n;
         normalTaken <= normalTaken || !normal_request_out_n;
      end
   end
endmodule

// [bench/tb_top.sv]
// Testbench: register-level tests of the irq command register block
`timescale 1ns/10ps
module tb_top;
   logic clock, nrst, writeStrobe, readStrobe;
   logic [7:0] address;
   logic [31:0] writeData, readData, sourceLevel, got;
   logic fast_request_out_n, normal_request_out_n, protection_enable;
   logic serviceBusy, eventIrq, fastTaken, normalTaken;
   int failures, comparisons;
   ////////////////////////////////////////////////////////////////////////
   vectored_irq_command_regs u_vectored_irq_command_regs (.clock, .nrst,
      .address, .writeData, .writeStrobe, .readStrobe, .readData,
      .sourceLevel, .fast_request_out_n, .normal_request_out_n,
      .protection_enable, .serviceBusy, .eventIrq);
   core_request_model u_core_request_model (.clock, .nrst,
      .fast_request_out_n, .normal_request_out_n, .fastTaken,
      .normalTaken);
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   // Write leaves its strobe up so writes can follow with no gap
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      readStrobe <= 1'b0;
      writeStrobe <= 1'b1;
      address <= a;
      writeData <= d;
      @(posedge clock);
   endtask
   task automatic idle();
      writeStrobe <= 1'b0;
      readStrobe <= 1'b0;
      @(posedge clock);
   endtask
   // Data is taken before this edge's updates land
   task automatic rd(input logic [7:0] a);
      writeStrobe <= 1'b0;
      readStrobe <= 1'b1;
      address <= a;
      @(posedge clock);
      idle();
      got = readData;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      check(got, exp);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   initial begin
      #20us;
      failures++;
      print_verdict();
   end
   initial begin
      nrst = 1'b0;
      writeStrobe = 1'b0;
      readStrobe = 1'b0;
      address = 8'h00;
      writeData = 32'h0000_0000;
      sourceLevel = 32'h0000_0000;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      rdc(8'h38, 32'h0000_0000);
      rdc(8'h34, 32'h0000_0000);
      rdc(8'h14, 32'h0000_0000);
      wr(8'h34, 32'h1234_5678);
      rdc(8'h34, 32'h1234_5678);
      rdc(8'h04, 32'h1234_5678);
      rdc(8'h08, 32'h1234_5678);
      wr(8'h20, 32'h0000_00f1);
      rdc(8'h10, 32'h0000_00f1);
      wr(8'h24, 32'h0000_0031);
      rdc(8'h10, 32'h0000_00c0);
      rdc(8'h20, 32'h0000_0000);
      wr(8'h00, 32'h0000_0a00);
      wr(8'h20, 32'h0000_0001);
      wr(8'h2c, 32'h0000_0001);
      idle();
      rdc(8'h0c, 32'h0000_0001);
      rdc(8'h14, 32'h0000_0001);
      rdc(8'h08, 32'h0000_0a00);
      check({31'h0, fastTaken}, 32'h0000_0001);
      wr(8'h28, 32'h0000_0001);
      idle();
      rdc(8'h14, 32'h0000_0000);
      wr(8'h2c, 32'h0000_0080);
      idle();
      rdc(8'h14, 32'h0000_0002);
      check({31'h0, normalTaken}, 32'h0000_0001);
      rd(8'h04);
      check({31'h0, serviceBusy}, 32'h0000_0001);
      rdc(8'h14, 32'h0000_0000);
      wr(8'h30, 32'hdead_beef);
      idle();
      rdc(8'h14, 32'h0000_0002);
      wr(8'h40, 32'hffff_ffff);
      rdc(8'h48, 32'hffff_fffe);
      wr(8'h44, 32'hffff_ff7f);
      rdc(8'h48, 32'h0000_0080);
      rdc(8'h14, 32'h0000_0001);
      wr(8'h38, 32'h0000_0002);
      idle();
      rdc(8'h14, 32'h0000_0000);
      wr(8'h38, 32'hffff_ffff);
      idle();
      idle();
      check({31'h0, protection_enable}, 32'h0000_0001);
      rdc(8'h38, 32'h0000_0003);
      wr(8'h38, 32'h0000_0000);
      idle();
      rdc(8'h14, 32'h0000_0001);
      wr(8'h28, 32'h0000_0080);
      wr(8'h44, 32'hffff_ffff);
      wr(8'h0c, 32'hffff_ffff);
      rdc(8'h0c, 32'h0000_0000);
      rdc(8'h48, 32'h0000_0000);
      rdc(8'h7c, 32'h0000_0000);
      sourceLevel <= 32'h0000_0010;
      idle();
      rdc(8'h0c, 32'h0000_0010);
      sourceLevel <= 32'h0000_0000;
      wr(8'h28, 32'h0000_0010);
      rdc(8'h0c, 32'h0000_0000);
      // Flush events left by the spurious vector reads and the end of service write above
      rd(8'h50);
      wr(8'h54, 32'h0000_0001);
      wr(8'h30, 32'h0000_0000);
      idle();
      idle();
      check({31'h0, eventIrq}, 32'h0000_0001);
      rdc(8'h50, 32'h0000_0001);
      idle();
      check({31'h0, eventIrq}, 32'h0000_0000);
      wr(8'h54, 32'h0000_0000);
      wr(8'h30, 32'h0000_0000);
      idle();
      idle();
      check({31'h0, eventIrq}, 32'h0000_0000);
      rdc(8'h50, 32'h0000_0001);
      print_verdict();
   end
endmodule
////////////////////////////////////////////////////////////////////////////
bind vectored_irq_command_regs vectored_irq_assertions
   u_vectored_irq_assertions (.clock, .nrst, .address, .writeData,
   .writeStrobe, .readStrobe, .readData, .fast_request_out_n,
   .normal_request_out_n, .serviceBusy);
